// [psil_pkg.sv]
`default_nettype none
package psil_pkg;

  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_KHZ         = 250000;
  localparam int unsigned FAST_LOSS_NS    = 1300;
  localparam int unsigned FAST_LOSS_CYC   = FAST_LOSS_NS * CLK_KHZ / 1000000;
  localparam int unsigned LINK_LOSS_MS    = 50;
  localparam int unsigned LINK_LOSS_CYC   = LINK_LOSS_MS * CLK_KHZ;
  localparam int unsigned BLINK_HZ_0      = 2;
  localparam int unsigned BLINK_HZ_1      = 5;
  localparam int unsigned BLINK_HZ_2      = 10;
  localparam int unsigned BLINK_HZ_3      = 20;
  localparam int unsigned BLINK_HALF_0    = CLK_KHZ * 1000 / (2 * BLINK_HZ_0);
  localparam int unsigned BLINK_HALF_1    = CLK_KHZ * 1000 / (2 * BLINK_HZ_1);
  localparam int unsigned BLINK_HALF_2    = CLK_KHZ * 1000 / (2 * BLINK_HZ_2);
  localparam int unsigned BLINK_HALF_3    = CLK_KHZ * 1000 / (2 * BLINK_HZ_3);
  localparam int unsigned STRAP_WAIT_CYC  = 16;
  localparam int unsigned NLP_LINK_COUNT  = 7;
  localparam int unsigned TIMER_W         = 27;

  // ------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [5:0] IDX_DIRECT_CTRL  = 6'h18;
  localparam logic [5:0] IDX_PHY_CTRL     = 6'h19;
  localparam logic [5:0] IDX_SD_CFG       = 6'h20;
  localparam logic [5:0] IDX_STATUS       = 6'h21;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int unsigned DC_VAL_LO       = 0;
  localparam int unsigned DC_EN_LO        = 3;
  localparam int unsigned DC_RATE_LO      = 6;
  localparam int unsigned DC_RX_ONLY      = 8;
  localparam int unsigned PC_MODE_LO      = 5;
  localparam int unsigned SD_FAST_BIT     = 0;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [15:0] DIRECT_CTRL_RST = 16'h0000;
  localparam logic [1:0]  MODE_RST        = 2'h1;
  localparam logic        SD_FAST_RST     = 1'b0;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_LINK_ACT,
    MODE_COLLISION,
    MODE_DUPLEX
  } psil_mode_t;

  typedef enum logic {
    ST_STRAP_WAIT,
    ST_RUN
  } psil_strap_t;

  function automatic psil_mode_t psil_decode_mode(input logic [1:0] cfg);
    psil_mode_t m;
    m = MODE_LINK_ACT;
    if (cfg[0] == 1'b1) begin
      m = MODE_LINK_ACT;
    end else if (cfg[1] == 1'b0) begin
      m = MODE_COLLISION;
    end else begin
      m = MODE_DUPLEX;
    end
    return m;
  endfunction

  function automatic logic [15:0] psil_merge(input logic [15:0] old_val,
                                             input logic [31:0] wdata,
                                             input logic [3:0]  be);
    logic [15:0] r;
    r = old_val;
    if (be[0]) begin
      r[7:0] = wdata[7:0];
    end
    if (be[1]) begin
      r[15:8] = wdata[15:8];
    end
    return r;
  endfunction

endpackage
`default_nettype wire

// [psil_link_if.sv]
`default_nettype none
interface psil_link_if;
  logic speed_100;
  logic sig_detect;
  logic nlp_pulse;
  logic good_packet;
  logic fast_loss_en;
  logic link_up;

  modport core (
    output speed_100,
    output sig_detect,
    output nlp_pulse,
    output good_packet,
    output fast_loss_en,
    input  link_up
  );

  modport qual (
    input  speed_100,
    input  sig_detect,
    input  nlp_pulse,
    input  good_packet,
    input  fast_loss_en,
    output link_up
  );
endinterface
`default_nettype wire

// [psil_link_qual.sv]
`default_nettype none
module psil_link_qual #(
  parameter int unsigned LOSS_CYC = psil_pkg::LINK_LOSS_CYC
) (
  // clock and reset
  input wire logic   clock,
  input wire logic   resetn,
  // status from and link state to the indicator core
  psil_link_if.qual  lnk
);
  import psil_pkg::*;

  localparam logic [TIMER_W-1:0] LOSS_LIM = TIMER_W'(LOSS_CYC - 1);
  localparam logic [TIMER_W-1:0] FAST_LIM = TIMER_W'(FAST_LOSS_CYC - 1);
  localparam logic [2:0]         NLP_LAST = 3'(NLP_LINK_COUNT - 1);

  logic [TIMER_W-1:0] loss_cnt;
  logic [2:0]         nlp_cnt;
  logic               link_up;
  logic [TIMER_W-1:0] limit;
  logic               expired;

  assign limit   = (lnk.speed_100 && lnk.fast_loss_en) ? FAST_LIM : LOSS_LIM;
  assign expired = (loss_cnt >= limit);
  assign lnk.link_up = link_up;

  // ------------------------------------------------------------
  // loss timer and link state
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      loss_cnt <= '0;
      nlp_cnt  <= '0;
      link_up  <= 1'b0;
    end else if (lnk.speed_100) begin
      nlp_cnt <= '0;
      if (lnk.sig_detect) begin
        loss_cnt <= '0;
        link_up  <= 1'b1;
      end else if (expired) begin
        link_up  <= 1'b0;
      end else begin
        loss_cnt <= loss_cnt + 1'b1;
      end
    end else if (lnk.good_packet) begin
      loss_cnt <= '0;
      link_up  <= 1'b1;
    end else if (lnk.nlp_pulse) begin
      loss_cnt <= '0;
      if (nlp_cnt == NLP_LAST) begin
        link_up <= 1'b1;
      end else begin
        nlp_cnt <= nlp_cnt + 1'b1;
      end
    end else if (expired) begin
      // pulse train broken: start counting again from zero
      nlp_cnt <= '0;
      link_up <= 1'b0;
    end else begin
      loss_cnt <= loss_cnt + 1'b1;
    end
  end

endmodule
`default_nettype wire

// [psil_top.sv]
// The Avalon-MM interface to the registers was left to the implementer.
`default_nettype none
// What this block does
// - Mode field low bit set: link output on for good link, off otherwise.
// - Mode field 00 or 10: link output on for link, blinks during activity.
// - Blink rate comes from the two-bit rate field, bits 7:6 of direct control.
// - Receive-only bit 8 clear counts transmit and receive; set counts receive only.
// - Mode 1: activity output on while transmit or receive activity present.
// - Mode 0: activity output shows collision status.
// - Mode 2: activity output shows duplex, on for full, off for half.
// - Speed output high at 100 Mb/s, low at 10, in every mode.
// - 10 Mb/s link after seven consecutive link pulses or one valid packet.
// - 100 Mb/s link declared when signal detect becomes true.
// - Link output drops when the standard link-loss timer expires.
// - Fast loss enabled at 100 Mb/s: link drops within about 1.3 us.
// - 10 Mb/s half-duplex collision indication follows MII COL.
// - Each strap sampled at reset: low gives active-high, high gives active-low.
// - Outputs can be driven directly; reading direct control never returns pins.
// - Mode field sits at bits 6:5 of the PHY control register, index 19h.
// - Mode field high bit is set by register write only, never strapped.
module psil_top #(
  parameter int unsigned LINK_LOSS_CYC = psil_pkg::LINK_LOSS_CYC,
  parameter int unsigned BLINK_HALF_0  = psil_pkg::BLINK_HALF_0,
  parameter int unsigned BLINK_HALF_1  = psil_pkg::BLINK_HALF_1,
  parameter int unsigned BLINK_HALF_2  = psil_pkg::BLINK_HALF_2,
  parameter int unsigned BLINK_HALF_3  = psil_pkg::BLINK_HALF_3
) (
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RESETN,
  // avalon-mm slave
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // transceiver status, same clock
  input  wire logic        SPEED_100,
  input  wire logic        FULL_DUPLEX,
  input  wire logic        TX_ACTIVE,
  input  wire logic        RX_ACTIVE,
  input  wire logic        MII_COL,
  input  wire logic        SIGNAL_DETECT_100,
  input  wire logic        NLP_RECEIVED,
  input  wire logic        VALID_PACKET_10,
  // link indicator pin
  input  wire logic        LINK_INDICATOR_IN,
  output logic             LINK_INDICATOR_OUT,
  output logic             LINK_INDICATOR_OE,
  // speed indicator pin
  input  wire logic        SPEED_INDICATOR_IN,
  output logic             SPEED_INDICATOR_OUT,
  output logic             SPEED_INDICATOR_OE,
  // activity indicator pin
  input  wire logic        ACTIVITY_INDICATOR_IN,
  output logic             ACTIVITY_INDICATOR_OUT,
  output logic             ACTIVITY_INDICATOR_OE
);
  import psil_pkg::*;

  localparam logic [TIMER_W-1:0] STRAP_LAST = TIMER_W'(STRAP_WAIT_CYC - 1);

  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------
  logic [15:0]        indicator_direct_ctrl;
  logic [1:0]         indicator_mode_cfg;
  logic               fast_loss_enable;

  logic               ack;
  logic [5:0]         reg_idx;
  logic               wr_go;
  logic [31:0]        next_readdata;

  logic [1:0]         flash_rate_sel;
  logic               activity_receive_only;
  logic [2:0]         direct_en;
  logic [2:0]         direct_val;

  // ------------------------------------------------------------
  // strap capture and pin synchronisers
  // ------------------------------------------------------------
  logic [2:0]         strap_meta;
  logic [2:0]         strap_sync;
  logic [2:0]         strap_level;
  psil_strap_t        strap_state;
  logic [TIMER_W-1:0] strap_cnt;

  // ------------------------------------------------------------
  // status and indicator logic
  // ------------------------------------------------------------
  logic               activity;
  logic               collision;
  logic               link_up;
  psil_mode_t         mode;
  logic [TIMER_W-1:0] blink_cnt;
  logic [TIMER_W-1:0] blink_lim;
  logic               blink_tick;
  logic               blink_phase;
  logic               link_status;
  logic               act_status;
  logic [2:0]         status_vec;
  logic [2:0]         drive_vec;
  logic [2:0]         pin_out;
  logic               pin_oe;

  psil_link_if        lnk ();

  assign flash_rate_sel        = indicator_direct_ctrl[DC_RATE_LO +: 2];
  assign activity_receive_only = indicator_direct_ctrl[DC_RX_ONLY];
  assign direct_en             = indicator_direct_ctrl[DC_EN_LO +: 3];
  assign direct_val            = indicator_direct_ctrl[DC_VAL_LO +: 3];

  // ------------------------------------------------------------
  // avalon slave: one wait cycle, then answer
  // ------------------------------------------------------------
  assign reg_idx         = AVS_ADDRESS[7:2];
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack;
  assign wr_go           = AVS_WRITE && ack;

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      ack <= 1'b0;
    end else begin
      ack <= (AVS_READ || AVS_WRITE) && !ack;
    end
  end

  always_comb begin
    next_readdata = 32'h0000_0000;
    unique case (reg_idx)
      IDX_DIRECT_CTRL: begin
        // stored bits only, never the live pins
        next_readdata[15:0] = indicator_direct_ctrl;
      end
      IDX_PHY_CTRL: begin
        next_readdata[PC_MODE_LO +: 2] = indicator_mode_cfg;
      end
      IDX_SD_CFG: begin
        next_readdata[SD_FAST_BIT] = fast_loss_enable;
      end
      IDX_STATUS: begin
        next_readdata[0]   = link_up;
        next_readdata[1]   = SPEED_100;
        next_readdata[2]   = FULL_DUPLEX;
        next_readdata[3]   = activity;
        next_readdata[4]   = collision;
        next_readdata[7:5] = strap_level;
        next_readdata[8]   = (strap_state == ST_RUN);
      end
      default: begin
        next_readdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (AVS_READ && !ack) begin
      AVS_READDATA <= next_readdata;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      indicator_direct_ctrl <= DIRECT_CTRL_RST;
    end else if (wr_go && reg_idx == IDX_DIRECT_CTRL) begin
      indicator_direct_ctrl <= psil_merge(indicator_direct_ctrl, AVS_WRITEDATA,
                                          AVS_BYTEENABLE);
    end
  end

  // high mode bit has no strap source, only this write path
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      indicator_mode_cfg <= MODE_RST;
    end else if (wr_go && reg_idx == IDX_PHY_CTRL && AVS_BYTEENABLE[0]) begin
      indicator_mode_cfg <= AVS_WRITEDATA[PC_MODE_LO +: 2];
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      fast_loss_enable <= SD_FAST_RST;
    end else if (wr_go && reg_idx == IDX_SD_CFG && AVS_BYTEENABLE[0]) begin
      fast_loss_enable <= AVS_WRITEDATA[SD_FAST_BIT];
    end
  end

  // ------------------------------------------------------------
  // strap pins: two-flop sync, latched once after reset
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      strap_meta <= 3'h0;
      strap_sync <= 3'h0;
    end else begin
      strap_meta <= {ACTIVITY_INDICATOR_IN, SPEED_INDICATOR_IN, LINK_INDICATOR_IN};
      strap_sync <= strap_meta;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      strap_state <= ST_STRAP_WAIT;
      strap_cnt   <= '0;
      strap_level <= 3'h0;
    end else begin
      unique case (strap_state)
        ST_STRAP_WAIT: begin
          if (strap_cnt == STRAP_LAST) begin
            strap_level <= strap_sync;
            strap_state <= ST_RUN;
          end else begin
            strap_cnt <= strap_cnt + 1'b1;
          end
        end
        ST_RUN: begin
          strap_state <= ST_RUN;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // link qualification
  // ------------------------------------------------------------
  assign lnk.speed_100    = SPEED_100;
  assign lnk.sig_detect   = SIGNAL_DETECT_100;
  assign lnk.nlp_pulse    = NLP_RECEIVED;
  assign lnk.good_packet  = VALID_PACKET_10;
  assign lnk.fast_loss_en = fast_loss_enable;
  assign link_up          = lnk.link_up;

  psil_link_qual #(
    .LOSS_CYC (LINK_LOSS_CYC)
  ) u_link_qual (
    .clock  (CLOCK),
    .resetn (RESETN),
    .lnk    (lnk.qual)
  );

  // ------------------------------------------------------------
  // activity, collision, mode
  // ------------------------------------------------------------
  assign activity  = activity_receive_only ? RX_ACTIVE : (RX_ACTIVE || TX_ACTIVE);
  // collision reporting is off in full duplex
  assign collision = MII_COL && !FULL_DUPLEX;
  assign mode      = psil_decode_mode(indicator_mode_cfg);

  // ------------------------------------------------------------
  // blink divider
  // ------------------------------------------------------------
  always_comb begin
    blink_lim = TIMER_W'(BLINK_HALF_0 - 1);
    unique case (flash_rate_sel)
      2'h0: blink_lim = TIMER_W'(BLINK_HALF_0 - 1);
      2'h1: blink_lim = TIMER_W'(BLINK_HALF_1 - 1);
      2'h2: blink_lim = TIMER_W'(BLINK_HALF_2 - 1);
      2'h3: blink_lim = TIMER_W'(BLINK_HALF_3 - 1);
    endcase
  end

  assign blink_tick = (blink_cnt >= blink_lim);

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      blink_cnt <= '0;
    end else if (blink_tick) begin
      blink_cnt <= '0;
    end else begin
      blink_cnt <= blink_cnt + 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      blink_phase <= 1'b0;
    end else if (blink_tick) begin
      blink_phase <= !blink_phase;
    end
  end

  // ------------------------------------------------------------
  // per-mode indicator functions
  // ------------------------------------------------------------
  always_comb begin
    link_status = link_up;
    act_status  = activity;
    unique case (mode)
      MODE_LINK_ACT: begin
        link_status = link_up;
        act_status  = activity;
      end
      MODE_COLLISION: begin
        link_status = link_up && !(activity && blink_phase);
        act_status  = collision;
      end
      MODE_DUPLEX: begin
        link_status = link_up && !(activity && blink_phase);
        act_status  = FULL_DUPLEX;
      end
    endcase
  end

  // bit order: 0 link, 1 speed, 2 activity
  assign status_vec = {act_status, SPEED_100, link_status};
  assign drive_vec  = (direct_en & direct_val) | (~direct_en & status_vec);

  // ------------------------------------------------------------
  // output pins: released until straps are latched
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      pin_out <= 3'h0;
      pin_oe  <= 1'b0;
    end else if (strap_state == ST_RUN) begin
      // strap high makes the output active low
      pin_out <= drive_vec ^ strap_level;
      pin_oe  <= 1'b1;
    end else begin
      pin_out <= 3'h0;
      pin_oe  <= 1'b0;
    end
  end

  assign LINK_INDICATOR_OUT     = pin_out[0];
  assign SPEED_INDICATOR_OUT    = pin_out[1];
  assign ACTIVITY_INDICATOR_OUT = pin_out[2];
  assign LINK_INDICATOR_OE      = pin_oe;
  assign SPEED_INDICATOR_OE     = pin_oe;
  assign ACTIVITY_INDICATOR_OE  = pin_oe;

endmodule
`default_nettype wire

// [psil_props.sv]
`default_nettype none
module psil_props #(
  parameter int unsigned LINK_LOSS_CYC = 40
) (
  // clock and reset
  input wire logic        CLOCK,
  input wire logic        RESETN,
  // register bus
  input wire logic [7:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0]  AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  // status and pins
  input wire logic        SPEED_100,
  input wire logic        FULL_DUPLEX,
  input wire logic        TX_ACTIVE,
  input wire logic        RX_ACTIVE,
  input wire logic        MII_COL,
  input wire logic        SIGNAL_DETECT_100,
  input wire logic        LINK_INDICATOR_IN,
  input wire logic        SPEED_INDICATOR_IN,
  input wire logic        ACTIVITY_INDICATOR_IN,
  input wire logic        LINK_INDICATOR_OUT,
  input wire logic        LINK_INDICATOR_OE,
  input wire logic        SPEED_INDICATOR_OUT,
  input wire logic        ACTIVITY_INDICATOR_OUT
);
  logic [15:0] dc;
  logic [1:0]  md;
  logic [2:0]  st;
  logic [4:0]  cnt;
  logic        wr_ok;

  // ------------------------------------------------------------
  // shadow state
  // ------------------------------------------------------------
  assign wr_ok = AVS_WRITE && !AVS_WAITREQUEST;
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      dc <= 16'h0000;
      md <= 2'h1;
    end else if (wr_ok && AVS_ADDRESS[7:2] == 6'h18) begin
      if (AVS_BYTEENABLE[0]) begin
        dc[7:0] <= AVS_WRITEDATA[7:0];
      end
      if (AVS_BYTEENABLE[1]) begin
        dc[15:8] <= AVS_WRITEDATA[15:8];
      end
    end else if (wr_ok && AVS_ADDRESS[7:2] == 6'h19 && AVS_BYTEENABLE[0]) begin
      md <= AVS_WRITEDATA[6:5];
    end
  end
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      cnt <= 5'h00;
    end else if (cnt != 5'h1f) begin
      cnt <= cnt + 5'h01;
    end
  end
  // strap level seen while pins float
  always_ff @(posedge CLOCK) begin
    if (!LINK_INDICATOR_OE) begin
      st <= {ACTIVITY_INDICATOR_IN, SPEED_INDICATOR_IN, LINK_INDICATOR_IN};
    end
  end

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);

  a_wait_one: assert property (
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("waitrequest held too long");
  a_read_direct: assert property (
    AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS[7:2] == 6'h18
    |-> AVS_READDATA == {16'h0000, dc}) else $error("direct control read wrong");
  a_oe_drives: assert property (
    cnt == 5'h14 |-> LINK_INDICATOR_OE) else $error("pins not driven after strap");
  a_speed_level: assert property (
    LINK_INDICATOR_OE && $past(LINK_INDICATOR_OE) |-> SPEED_INDICATOR_OUT ==
    (st[1] ^ ($past(dc[4]) ? $past(dc[1]) : $past(SPEED_100))))
    else $error("speed pin wrong");
  a_act_duplex: assert property (
    LINK_INDICATOR_OE && $past(LINK_INDICATOR_OE) && $past(md) == 2'h2 && !$past(dc[5])
    |-> ACTIVITY_INDICATOR_OUT == (st[2] ^ $past(FULL_DUPLEX))) else $error("duplex wrong");
  a_act_coll: assert property (
    LINK_INDICATOR_OE && $past(LINK_INDICATOR_OE) && $past(md) == 2'h0 && !$past(dc[5])
    |-> ACTIVITY_INDICATOR_OUT == (st[2] ^ $past(MII_COL && !FULL_DUPLEX)))
    else $error("collision wrong");
  a_act_traffic: assert property (
    LINK_INDICATOR_OE && $past(LINK_INDICATOR_OE) && $past(md[0]) && !$past(dc[5])
    |-> ACTIVITY_INDICATOR_OUT == (st[2] ^ $past(RX_ACTIVE || (TX_ACTIVE && !dc[8]))))
    else $error("activity wrong");
  a_link_detect: assert property (
    (SPEED_100 && SIGNAL_DETECT_100 && md[0] && !dc[3] && LINK_INDICATOR_OE) [*3]
    |=> LINK_INDICATOR_OUT == !st[0]) else $error("link pin not on");

  c_blink: cover property (md == 2'h0 && RX_ACTIVE && LINK_INDICATOR_OE);
  c_direct: cover property (dc[5:3] == 3'h7);
  c_drop: cover property ($fell(LINK_INDICATOR_OUT));
endmodule
bind psil_top psil_props #(.LINK_LOSS_CYC(LINK_LOSS_CYC)) i_props (.*);
`default_nettype wire

// [psil_leds.sv]
`default_nettype none
module psil_leds (
  // resistor level of each pin
  input  wire logic [2:0] strap,
  // drive from the device
  input  wire logic [2:0] out,
  input  wire logic [2:0] oe,
  // resolved pin level
  output logic      [2:0] pin
);
  // undriven pin rests at its strap resistor
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin[i] = oe[i] ? out[i] : strap[i];
    end
  end
endmodule
`default_nettype wire

// [phy_status_indicator_logic_tb.sv]
`default_nettype none
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin n_mismatch++; \
  $display("ERROR %s expected %h seen %h", nm, e, s); end end
module phy_status_indicator_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import psil_pkg::*;
  logic        clock;
  logic        resetn;
  logic        rd;
  logic        wr;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [3:0]  be;
  wire  [31:0] rdata;
  wire         wait_req;
  logic        spd;
  logic        fdx;
  logic        tx;
  logic        rx;
  logic        col;
  logic        sd;
  logic        nlp;
  logic        pkt;
  logic [2:0]  strap;
  wire  [2:0]  out;
  wire  [2:0]  oe;
  wire  [2:0]  pin;
  logic [15:0] lfsr;
  logic [31:0] q;
  logic [15:0] d;
  logic [1:0]  mds [3] = '{2'h1, 2'h0, 2'h2};
  int          half [4] = '{4, 5, 6, 8};
  int          n_mismatch;
  int          checks;
  int          n;

  psil_top #(.LINK_LOSS_CYC(40), .BLINK_HALF_0(4), .BLINK_HALF_1(5), .BLINK_HALF_2(6),
    .BLINK_HALF_3(8)) i_dut (.CLOCK(clock), .RESETN(resetn), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req), .SPEED_100(spd), .FULL_DUPLEX(fdx),
    .TX_ACTIVE(tx), .RX_ACTIVE(rx), .MII_COL(col), .SIGNAL_DETECT_100(sd),
    .NLP_RECEIVED(nlp), .VALID_PACKET_10(pkt), .LINK_INDICATOR_IN(pin[0]),
    .LINK_INDICATOR_OUT(out[0]), .LINK_INDICATOR_OE(oe[0]), .SPEED_INDICATOR_IN(pin[1]),
    .SPEED_INDICATOR_OUT(out[1]), .SPEED_INDICATOR_OE(oe[1]),
    .ACTIVITY_INDICATOR_IN(pin[2]), .ACTIVITY_INDICATOR_OUT(out[2]),
    .ACTIVITY_INDICATOR_OE(oe[2]));
  psil_leds i_leds (.strap(strap), .out(out), .oe(oe), .pin(pin));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [2:0] model(input logic [1:0] md, input logic [15:0] c,
                                       input logic lk);
    logic [2:0] s;
    s[0] = lk;
    s[1] = spd;
    s[2] = md[0] ? (rx | (tx & !c[8])) : (md[1] ? fdx : (col & !fdx));
    for (int i = 0; i < 3; i++) begin
      if (c[3 + i]) begin
        s[i] = c[i];
      end
    end
    return s;
  endfunction
  task automatic settle(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] v);
    logic wq;
    int   k;
    k = 0;
    @(posedge clock);
    {wr, rd, addr, wdata, be} <= {w, !w, a, 16'h0000, v, 4'h3};
    do begin
      #1;
      wq = wait_req;
      q = rdata;
      @(posedge clock);
      k++;
    end while (wq !== 1'b0 && k < 20);
    {wr, rd} <= 2'h0;
    if (k >= 20) n_mismatch++;
  endtask
  task automatic rst(input logic [2:0] s);
    @(posedge clock);
    {strap, spd, sd, rx, tx, resetn} <= {s, 5'h00};
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    settle(20);
  endtask
  task automatic pls(input logic p);
    @(posedge clock);
    {pkt, nlp} <= {p, !p};
    @(posedge clock);
    {pkt, nlp} <= 2'h0;
    repeat (3) @(posedge clock);
  endtask
  task automatic lk(input int k, input logic e);
    settle(k);
    `CHK("link_pin", e ^ strap[0], pin[0])
  endtask
  task automatic run_len(output int k);
    logic v;
    #1;
    repeat (3) begin
      k = 0;
      v = pin[0];
      while (pin[0] === v && k < 99) begin
        settle(1);
        k++;
      end
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    repeat (8000) @(posedge clock);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    {rd, wr, addr, wdata, be, fdx, col, nlp, pkt} = '0;
    {strap, spd, sd, rx, tx, resetn, n_mismatch, checks} = '0;
    lfsr = 16'd15270;
    rst(3'h0);
    `CHK("oe", 3'h7, oe)
    bus(1'b0, 8'h60, 16'h0000);
    `CHK("direct_ctrl", {16'h0000, DIRECT_CTRL_RST}, q)
    bus(1'b0, 8'h64, 16'h0000);
    `CHK("phy_ctrl", {25'h0, MODE_RST, 5'h00}, q)
    bus(1'b1, 8'h10, 16'hffff);
    bus(1'b0, 8'h10, 16'h0000);
    `CHK("unmapped", 32'h0, q)
    $display("registers done");
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, 8'h64, {9'h000, mds[m], 5'h00});
      lfsr = step(lfsr);
      d = {7'h00, lfsr[8:0]};
      bus(1'b1, 8'h60, d);
      bus(1'b0, 8'h60, 16'h0000);
      `CHK("direct_rb", {16'h0000, d}, q)
      repeat (12) begin
        @(posedge clock);
        lfsr = step(lfsr);
        {rx, tx, col, fdx, spd} <= lfsr[4:0];
        settle(3);
        `CHK("pins", model(mds[m], d, 1'b0) ^ strap, pin)
      end
    end
    $display("modes done");
    bus(1'b1, 8'h60, 16'h0000);
    bus(1'b1, 8'h64, 16'h0020);
    @(posedge clock);
    {rx, tx, col, fdx, spd, sd} <= 6'h03;
    lk(4, 1'b1);
    @(posedge clock);
    sd <= 1'b0;
    lk(30, 1'b1);
    lk(15, 1'b0);
    bus(1'b1, 8'h80, 16'h0001);
    @(posedge clock);
    sd <= 1'b1;
    lk(4, 1'b1);
    @(posedge clock);
    sd <= 1'b0;
    lk(300, 1'b1);
    lk(40, 1'b0);
    bus(1'b1, 8'h80, 16'h0000);
    @(posedge clock);
    spd <= 1'b0;
    repeat (6) pls(1'b0);
    lk(1, 1'b0);
    pls(1'b0);
    lk(1, 1'b1);
    lk(45, 1'b0);
    pls(1'b1);
    lk(1, 1'b1);
    $display("link done");
    @(posedge clock);
    {spd, sd, rx} <= 3'h7;
    bus(1'b1, 8'h64, 16'h0000);
    for (int r = 0; r < 4; r++) begin
      bus(1'b1, 8'h60, {8'h00, r[1:0], 6'h00});
      run_len(n);
      `CHK("blink_half", half[r], n)
    end
    $display("blink done");
    rst(3'h5);
    `CHK("idle_pins", 3'h5, pin)
    bus(1'b0, 8'h84, 16'h0000);
    `CHK("straps", 4'hd, q[8:5])
    bus(1'b0, 8'h64, 16'h0000);
    `CHK("mode_hi", 32'h20, q)
    @(posedge clock);
    {spd, sd} <= 2'h3;
    settle(5);
    `CHK("pol_pins", 3'h6, pin)
    $display("strap done");
    tally_and_finish();
  end
endmodule
`undef CHK
`default_nettype wire
